// *** logic/ssp_pkg.sv ***
// Constants, types and field layout for the serial EEPROM port.
// Assumes a single 250 MHz system clock samples every serial pin.
// How it works
// - Output changes only on serial clock falls
// - Input bits captured on serial clock rises
// - Select high: deselected, output high impedance
// - Standby only when no write cycle runs
// - Select low: selected and in active power
// - Ignore traffic until first select falling edge
// - Pause keeps selection and transfer position
// - Paused: output off, input and clock ignored
// - Lock input freezes the block-protect bits
// - Input bytes arrive most significant bit first
// - First bit on first rise after select
// - Read data MSB first from first fall after instruction and any address bytes
// - Both idle-low and idle-high clock modes work
// - Byte array of 4096 or 8192 bytes, decoded
// - Pause starts and ends only with clock low
// - Deselect during pause resets the interface
package ssp_pkg;
   localparam int PIN_N = 5;
   localparam int PIN_SCK = 0;
   localparam int PIN_SEL = 1;
   localparam int PIN_MOSI = 2;
   localparam int PIN_PAUSE = 3;
   localparam int PIN_LOCK = 4;
   localparam int BYTE_W = 8;
   localparam int BIT_CNT_W = 3;
   localparam int HDR_CNT_W = 2;
   localparam int ADDR_IN_W = 16;
   localparam int MEM_SMALL_BYTES = 4096;
   localparam int MEM_LARGE_BYTES = 8192;
   localparam int BUF_DEPTH = 2;
   localparam logic [1:0] BP_NONE = 2'h0;
   localparam logic [1:0] BP_QUARTER = 2'h1;
   localparam logic [1:0] BP_HALF = 2'h2;
   localparam logic [1:0] BP_ALL = 2'h3;
   localparam logic [1:0] BP_RESET = 2'h0;
   localparam logic [1:0] HDR_NONE = 2'h0;
   localparam logic [1:0] HDR_STATUS = 2'h1;
   localparam logic [1:0] HDR_ARRAY = 2'h3;
   localparam logic [7:0] OP_READ_ARRAY_DEF = 8'h03;
   localparam logic [7:0] OP_READ_STATUS_DEF = 8'h05;
   localparam logic [7:0] TX_IDLE_BYTE = 8'hFF;
   typedef enum logic [1:0] {PH_OFF, PH_IN, PH_OUT} ssp_phase_t;
endpackage : ssp_pkg

// *** logic/ssp_port.sv ***
// Serial peripheral port of a byte-organised EEPROM, oversampled by the system clock.
// Assumes the core drains received bytes and feeds read bytes on the same clock.
`timescale 1ns/100ps
`default_nettype none
module ssp_port import ssp_pkg::*; #(
   parameter int MEM_BYTES = MEM_SMALL_BYTES,
   parameter logic [7:0] OP_READ_ARRAY = OP_READ_ARRAY_DEF,
   parameter logic [7:0] OP_READ_STATUS = OP_READ_STATUS_DEF
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic sck_pin,
   input wire logic select_n_pin,
   input wire logic mosi_pin,
   input wire logic pause_n_pin,
   input wire logic lock_n_pin,
   output logic miso_o,
   output logic miso_oe,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_first,
   input wire logic rx_ready,
   output logic rx_fill_ready,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   input wire logic write_busy,
   input wire logic bp_wr,
   input wire logic [1:0] bp_wdata,
   output logic block_protect_hi,
   output logic block_protect_lo,
   output logic [$clog2(MEM_BYTES)-1:0] addr_o,
   output logic addr_protected,
   output logic selected_o,
   output logic paused_o,
   output logic low_power_o
);
   localparam int ADDR_W = $clog2(MEM_BYTES);

   function automatic logic [1:0] hdr_len(input logic [7:0] op);
      if (op == OP_READ_ARRAY) begin
         hdr_len = HDR_ARRAY;
      end else if (op == OP_READ_STATUS) begin
         hdr_len = HDR_STATUS;
      end else begin
         hdr_len = HDR_NONE;
      end
   endfunction : hdr_len

   function automatic logic is_prot(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
      unique case (bp)
         BP_NONE: is_prot = 1'b0;
         BP_QUARTER: is_prot = &a[ADDR_W-1 -: 2];
         BP_HALF: is_prot = a[ADDR_W-1];
         BP_ALL: is_prot = 1'b1;
      endcase
   endfunction : is_prot

   // Pin synchronisers
   logic [PIN_N-1:0] pin_raw;
   logic [PIN_N-1:0] sync1_q;
   logic [PIN_N-1:0] sync2_q;
   logic [PIN_N-1:0] prev_q;
   assign pin_raw = {lock_n_pin, pause_n_pin, mosi_pin, select_n_pin, sck_pin};
   for (genvar i = 0; i < PIN_N; i++) begin : g_sync
      always_ff @(posedge clock or negedge arst_n) begin
         if (!arst_n) begin
            sync1_q[i] <= 1'b0;
            sync2_q[i] <= 1'b0;
            prev_q[i] <= 1'b0;
         end else begin
            sync1_q[i] <= pin_raw[i];
            sync2_q[i] <= sync1_q[i];
            prev_q[i] <= sync2_q[i];
         end
      end
   end

   logic sck_lvl;
   logic sel_n_lvl;
   logic mosi_lvl;
   logic pause_n_lvl;
   logic lock_n_lvl;
   logic sck_rise;
   logic sck_fall;
   logic sel_fall;
   assign sck_lvl = sync2_q[PIN_SCK];
   assign sel_n_lvl = sync2_q[PIN_SEL];
   assign mosi_lvl = sync2_q[PIN_MOSI];
   assign pause_n_lvl = sync2_q[PIN_PAUSE];
   assign lock_n_lvl = sync2_q[PIN_LOCK];
   // Edges only, so an idle-high or idle-low clock works alike
   assign sck_rise = sck_lvl & ~prev_q[PIN_SCK];
   assign sck_fall = ~sck_lvl & prev_q[PIN_SCK];
   assign sel_fall = ~sel_n_lvl & prev_q[PIN_SEL];

   // Port state
   ssp_phase_t phase_q, phase_d;
   logic armed_q, armed_d;
   logic paused_q, paused_d;
   logic hdr_done_q, hdr_done_d;
   logic [BIT_CNT_W-1:0] bit_q, bit_d;
   logic [BIT_CNT_W-1:0] tx_bit_q, tx_bit_d;
   logic [HDR_CNT_W-1:0] byte_q, byte_d;
   logic [7:0] op_q, op_d;
   logic [7:0] sh_in_q, sh_in_d;
   logic [7:0] tx_sh_q, tx_sh_d;
   logic miso_q, miso_d;
   logic first_bit_q, first_bit_d;
   logic [ADDR_IN_W-1:0] addr_q, addr_d;
   logic [1:0] bp_q, bp_d;
   logic active;
   logic push;
   logic [7:0] push_byte;
   logic [7:0] tx_word;

   assign active = (phase_q != PH_OFF) & ~paused_q;

   always_comb begin
      phase_d = phase_q;
      armed_d = armed_q | sel_fall;
      paused_d = paused_q;
      hdr_done_d = hdr_done_q;
      bit_d = bit_q;
      tx_bit_d = tx_bit_q;
      byte_d = byte_q;
      op_d = op_q;
      sh_in_d = sh_in_q;
      tx_sh_d = tx_sh_q;
      miso_d = miso_q;
      first_bit_d = first_bit_q;
      addr_d = addr_q;
      push = 1'b0;
      push_byte = {sh_in_q[6:0], mosi_lvl};
      tx_word = tx_valid ? tx_data : TX_IDLE_BYTE;
      tx_ready = 1'b0;
      // Locked protect bits cannot change
      bp_d = (bp_wr & lock_n_lvl) ? bp_wdata : bp_q;
      if (sel_n_lvl) begin
         // Deselect, even while paused, drops the transfer
         phase_d = PH_OFF;
         paused_d = 1'b0;
         hdr_done_d = 1'b0;
      end else if (sel_fall && armed_d) begin
         // Fresh frame: first rise takes bit 7
         phase_d = PH_IN;
         bit_d = '0;
         tx_bit_d = '0;
         byte_d = '0;
         hdr_done_d = 1'b0;
      end else if (phase_q != PH_OFF) begin
         // Pause only enters or leaves with clock low
         if (!sck_lvl) begin
            paused_d = ~pause_n_lvl;
         end
         if (!paused_q && sck_rise) begin
            sh_in_d = push_byte;
            bit_d = bit_q + 1'b1;
            if (bit_q == '0) begin
               first_bit_d = mosi_lvl;
            end
            if (bit_q == 3'h7) begin
               push = 1'b1;
               if (byte_q != 2'h3) begin
                  byte_d = byte_q + 1'b1;
               end
               if (byte_q == 2'h0) begin
                  op_d = push_byte;
                  hdr_done_d = (hdr_len(push_byte) == HDR_STATUS);
               end else begin
                  addr_d = {addr_q[7:0], push_byte};
                  hdr_done_d = (phase_q == PH_IN) && (hdr_len(op_q) != HDR_NONE)
                     && (hdr_len(op_q) == byte_q + 1'b1);
               end
            end
         end
         if (!paused_q && sck_fall && (hdr_done_q || phase_q == PH_OUT)) begin
            // Read bytes leave MSB first from the first fall
            phase_d = PH_OUT;
            hdr_done_d = 1'b0;
            tx_bit_d = tx_bit_q + 1'b1;
            if (tx_bit_q == '0) begin
               tx_ready = tx_valid;
               miso_d = tx_word[7];
               tx_sh_d = {tx_word[6:0], 1'b0};
            end else begin
               miso_d = tx_sh_q[7];
               tx_sh_d = {tx_sh_q[6:0], 1'b0};
            end
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         phase_q <= PH_OFF;
         armed_q <= 1'b0;
         paused_q <= 1'b0;
         hdr_done_q <= 1'b0;
         bit_q <= '0;
         tx_bit_q <= '0;
         byte_q <= '0;
         op_q <= '0;
         sh_in_q <= '0;
         tx_sh_q <= '0;
         miso_q <= 1'b0;
         first_bit_q <= 1'b0;
         addr_q <= '0;
         bp_q <= BP_RESET;
      end else begin
         phase_q <= phase_d;
         armed_q <= armed_d;
         paused_q <= paused_d;
         hdr_done_q <= hdr_done_d;
         bit_q <= bit_d;
         tx_bit_q <= tx_bit_d;
         byte_q <= byte_d;
         op_q <= op_d;
         sh_in_q <= sh_in_d;
         tx_sh_q <= tx_sh_d;
         miso_q <= miso_d;
         first_bit_q <= first_bit_d;
         addr_q <= addr_d;
         bp_q <= bp_d;
      end
   end

   // Receive buffer, two entries
   logic [8:0] buf_q [BUF_DEPTH];
   logic [8:0] buf_d [BUF_DEPTH];
   logic wr_ptr_q, wr_ptr_d;
   logic rd_ptr_q, rd_ptr_d;
   logic [1:0] cnt_q, cnt_d;
   logic push_ok;
   logic pop;

   assign rx_fill_ready = (cnt_q != 2'(BUF_DEPTH));
   assign rx_valid = (cnt_q != 2'h0);
   assign push_ok = push & rx_fill_ready;
   assign pop = rx_valid & rx_ready;
   assign rx_data = buf_q[rd_ptr_q][7:0];
   assign rx_first = buf_q[rd_ptr_q][8];

   always_comb begin
      buf_d = buf_q;
      wr_ptr_d = wr_ptr_q ^ push_ok;
      rd_ptr_d = rd_ptr_q ^ pop;
      cnt_d = cnt_q + {1'b0, push_ok} - {1'b0, pop};
      if (push_ok) begin
         buf_d[wr_ptr_q] = {(byte_q == 2'h0), push_byte};
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         buf_q <= '{default: '0};
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         buf_q <= buf_d;
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         cnt_q <= cnt_d;
      end
   end

   // Outputs
   assign miso_o = miso_q;
   assign miso_oe = (phase_q == PH_OUT) & ~paused_q;
   assign block_protect_hi = bp_q[1];
   assign block_protect_lo = bp_q[0];
   assign addr_o = addr_q[ADDR_W-1:0];
   assign addr_protected = is_prot(addr_q[ADDR_W-1:0], bp_q);
   assign selected_o = (phase_q != PH_OFF);
   assign paused_o = paused_q;
   assign low_power_o = (phase_q == PH_OFF) & ~write_busy;

   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   sequence s_hdr_fall;
      hdr_done_q && sck_fall && active && !sel_n_lvl;
   endsequence
   sequence s_sel_start;
      sel_fall && armed_d;
   endsequence

   AST_DESELECT_HIZ: assert property (sel_n_lvl |=> !miso_oe && !selected_o)
      else $error("output driven while deselected");
   AST_OUT_ON_FALL: assert property ($changed(miso_o) |-> $past(sck_fall))
      else $error("serial output changed without a clock fall");
   AST_PAUSE_HIZ: assert property (paused_o |-> !miso_oe)
      else $error("output driven while paused");
   AST_PAUSE_FROZEN: assert property (paused_q ##1 paused_q |-> $stable(bit_q) && $stable(sh_in_q))
      else $error("transfer position moved during pause");
   AST_NOT_ARMED: assert property (!armed_q |-> !selected_o)
      else $error("selected before first select fall");
   AST_SELECT_ACTIVE: assert property (s_sel_start |=> selected_o && !low_power_o)
      else $error("select did not enter active power");
   AST_BUSY_AWAKE: assert property (write_busy |-> !low_power_o)
      else $error("standby during write cycle");
   AST_MSB_FIRST: assert property (push_ok |-> push_byte[7] == first_bit_q)
      else $error("first received bit not in bit 7");
   AST_LOCK_FREEZE: assert property (!lock_n_lvl |=> $stable(bp_q))
      else $error("protect bits changed while locked");
   AST_OUT_START: assert property (s_hdr_fall |=> miso_oe ##0 tx_bit_q == 3'h1)
      else $error("read output did not start on first fall");
   AST_PAUSE_ABANDON: assert property (paused_q && sel_n_lvl |=> !paused_q && !selected_o)
      else $error("deselect during pause did not reset");
   AST_PAUSE_ENTRY: assert property ($rose(paused_q) |-> $past(!sck_lvl && !pause_n_lvl))
      else $error("pause entered with clock high");
endmodule : ssp_port
`default_nettype wire

// *** tb/ssp_master.sv ***
// Bus master model for the serial port pins, stepped by the system clock.
// Assumes six system clocks per half link period, giving a 48 ns link clock.
`timescale 1ns/100ps
`default_nettype none
module ssp_master (
   input wire logic clock,
   input wire logic miso_o,
   input wire logic miso_oe,
   output logic sck,
   output logic sel_n,
   output logic mosi,
   output logic pause_n
);
   // Starts selected to probe the power-up guard
   initial begin
      sck = 1'b0;
      sel_n = 1'b0;
      mosi = 1'b0;
      pause_n = 1'b1;
   end
   task automatic wait_n(input int n);
      repeat (n) @(posedge clock);
   endtask : wait_n
   // One bit: data set with clock low, read back at the rise
   task automatic shift_bit(input logic b, output logic q);
      sck <= 1'b0;
      mosi <= b;
      wait_n(6);
      sck <= 1'b1;
      q = miso_oe ? miso_o : 1'bx;
      wait_n(6);
   endtask : shift_bit
   // Whole byte, most significant bit first
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         shift_bit(tx[i], rx[i]);
      end
   endtask : xfer
   // High then low on select, clock parked at its idle level
   task automatic frame_start(input logic pol);
      sck <= pol;
      sel_n <= 1'b1;
      wait_n(6);
      sel_n <= 1'b0;
      wait_n(6);
   endtask : frame_start
   // Clock back to idle with no extra pulse, then deselect
   task automatic frame_end(input logic pol);
      sck <= pol;
      wait_n(6);
      sel_n <= 1'b1;
      wait_n(12);
   endtask : frame_end
   // Pause changes only with the clock low, select kept low
   task automatic pause(input logic on);
      sck <= 1'b0;
      wait_n(6);
      pause_n <= ~on;
      wait_n(6);
   endtask : pause
endmodule : ssp_master
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the serial EEPROM port.
// Assumes the master model drives all link pins but lock; core side and lock driven here.
`timescale 1ns/100ps
`default_nettype none
module tb;
   import ssp_pkg::*;
   logic clock;
   logic arst_n;
   logic lock_n;
   logic rx_ready;
   logic tx_valid;
   logic [7:0] tx_data;
   logic write_busy;
   logic bp_wr;
   logic [1:0] bp_wdata;
   int tx_takes;
   wire logic sck, sel_n, mosi, pause_n, miso_o, miso_oe, rx_valid, rx_first;
   wire logic rx_fill_ready, tx_ready, bp_hi, bp_lo, addr_prot, sel_o, paused, low_pwr;
   wire logic [7:0] rx_data;
   wire logic [11:0] addr;
   logic [8:0] rxq[$];
   logic [7:0] q;
   int num_errors = 0;
   int num_checks = 0;
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   ssp_master ssp_master_i (.clock(clock), .miso_o(miso_o), .miso_oe(miso_oe), .sck(sck),
      .sel_n(sel_n), .mosi(mosi), .pause_n(pause_n));
   ssp_port ssp_port_i (.clock(clock), .arst_n(arst_n), .sck_pin(sck), .select_n_pin(sel_n),
      .mosi_pin(mosi), .pause_n_pin(pause_n), .lock_n_pin(lock_n), .miso_o(miso_o),
      .miso_oe(miso_oe), .rx_valid(rx_valid), .rx_data(rx_data), .rx_first(rx_first),
      .rx_ready(rx_ready), .rx_fill_ready(rx_fill_ready), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .write_busy(write_busy), .bp_wr(bp_wr),
      .bp_wdata(bp_wdata), .block_protect_hi(bp_hi), .block_protect_lo(bp_lo),
      .addr_o(addr), .addr_protected(addr_prot), .selected_o(sel_o), .paused_o(paused),
      .low_power_o(low_pwr));
   always @(posedge clock) begin
      if (rx_valid === 1'b1 && rx_ready) begin
         rxq.push_back({rx_first, rx_data});
      end
      if (tx_ready === 1'b1) begin
         tx_takes++;
      end
   end
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic pop(input logic [8:0] exp);
      chk("queue size", 16'h1, 16'(rxq.size() > 0));
      if (rxq.size() > 0) begin
         chk("rx byte", 16'(exp), 16'(rxq.pop_front()));
      end
   endtask : pop
   task automatic t_guard();
      ssp_master_i.xfer(8'h05, q);
      chk("selected", 16'h0, 16'(sel_o));
      chk("rx count", 16'h0, 16'(rxq.size()));
      chk("oe idle", 16'h0, 16'(miso_oe));
   endtask : t_guard
   task automatic t_status(input logic pol, input logic [7:0] d, input logic v);
      int t0;
      tx_data <= d;
      tx_valid <= v;
      t0 = tx_takes;
      ssp_master_i.frame_start(pol);
      chk("active", 16'h0, 16'(low_pwr));
      ssp_master_i.xfer(OP_READ_STATUS_DEF, q);
      ssp_master_i.xfer(8'h00, q);
      chk("read data", v ? 16'(d) : 16'(TX_IDLE_BYTE), 16'(q));
      ssp_master_i.frame_end(pol);
      chk("tx takes", 16'(v ? 2 - pol : 0), 16'(tx_takes - t0));
      chk("oe off", 16'h0, 16'(miso_oe));
      chk("standby", 16'h1, 16'(low_pwr));
      pop({1'b1, OP_READ_STATUS_DEF});
      pop(9'h000);
   endtask : t_status
   task automatic t_buffer();
      rx_ready <= 1'b0;
      ssp_master_i.frame_start(1'b0);
      ssp_master_i.xfer(8'h06, q);
      ssp_master_i.xfer(8'hA1, q);
      ssp_master_i.xfer(8'hB2, q);
      ssp_master_i.xfer(8'hC3, q);
      chk("buffer full", 16'h0, 16'(rx_fill_ready));
      ssp_master_i.shift_bit(1'b0, q[0]);
      chk("oe write op", 16'h0, 16'(miso_oe));
      ssp_master_i.frame_end(1'b0);
      rx_ready <= 1'b1;
      ssp_master_i.wait_n(4);
      pop(9'h106);
      pop(9'h0A1);
      chk("third dropped", 16'h0, 16'(rxq.size()));
   endtask : t_buffer
   task automatic t_array();
      bp_wdata <= BP_QUARTER;
      bp_wr <= 1'b1;
      ssp_master_i.wait_n(1);
      bp_wr <= 1'b0;
      tx_data <= 8'h3C;
      tx_valid <= 1'b1;
      ssp_master_i.frame_start(1'b1);
      ssp_master_i.xfer(OP_READ_ARRAY_DEF, q);
      ssp_master_i.xfer(8'h0F, q);
      ssp_master_i.xfer(8'hFF, q);
      chk("address", 16'h0FFF, 16'(addr));
      chk("protected", 16'h1, 16'(addr_prot));
      ssp_master_i.xfer(8'h00, q);
      chk("array data", 16'h3C, 16'(q));
      ssp_master_i.frame_end(1'b1);
      lock_n <= 1'b0;
      ssp_master_i.wait_n(3);
      bp_wdata <= BP_NONE;
      bp_wr <= 1'b1;
      ssp_master_i.wait_n(1);
      bp_wr <= 1'b0;
      ssp_master_i.wait_n(2);
      chk("bp frozen", 16'(BP_QUARTER), 16'({bp_hi, bp_lo}));
      lock_n <= 1'b1;
      rxq.delete();
   endtask : t_array
   task automatic t_pause();
      logic b;
      ssp_master_i.frame_start(1'b0);
      for (int i = 7; i >= 4; i--) ssp_master_i.shift_bit(1'(8'hA6 >> i), b);
      ssp_master_i.pause(1'b1);
      chk("paused", 16'h1, 16'(paused));
      ssp_master_i.shift_bit(1'b1, b);
      ssp_master_i.shift_bit(1'b0, b);
      chk("oe paused", 16'h0, 16'(miso_oe));
      chk("still selected", 16'h1, 16'(sel_o));
      ssp_master_i.pause(1'b0);
      chk("resumed", 16'h0, 16'(paused));
      for (int i = 3; i >= 0; i--) ssp_master_i.shift_bit(1'(8'hA6 >> i), b);
      ssp_master_i.frame_end(1'b0);
      pop(9'h1A6);
   endtask : t_pause
   task automatic t_power();
      write_busy <= 1'b1;
      ssp_master_i.wait_n(2);
      chk("busy active", 16'h0, 16'(low_pwr));
      write_busy <= 1'b0;
   endtask : t_power
   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report
   initial begin
      arst_n <= 1'b0;
      lock_n <= 1'b1;
      rx_ready <= 1'b1;
      tx_valid <= 1'b1;
      tx_data <= 8'h00;
      write_busy <= 1'b0;
      bp_wr <= 1'b0;
      bp_wdata <= BP_NONE;
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      repeat (4) @(posedge clock);
      t_guard();
      t_status(1'b0, 8'hA5, 1'b1);
      t_status(1'b1, 8'h5A, 1'b1);
      t_status(1'b0, 8'hC3, 1'b0);
      t_buffer();
      t_array();
      t_pause();
      t_power();
      final_report();
   end
   initial begin
      repeat (20000) @(posedge clock);
      num_errors++;
      final_report();
   end
endmodule : tb
`default_nettype wire
